/* design/pflc_defines.vh */
/*
  Register indices, field positions and reset values of the per-port
  forwarding, queue and lookup control bank.
  Assumes a 32-bit AHB-Lite slave where byte address = 4 * index.
*/
`ifndef PFLC_DEFINES_VH
`define PFLC_DEFINES_VH

// Printed offsets are register indices; the byte address is index * 4.
`define PFLC_IDX_QUEUE_CTRL_ZERO   14'h0A00
`define PFLC_IDX_FWD_MEMBERSHIP    14'h0A04
`define PFLC_IDX_TXQ_MEM_USAGE     14'h0A10
`define PFLC_IDX_LOOKUP_CTRL       14'h0B00
`define PFLC_IDX_STP_INDEX         14'h0B01
`define PFLC_IDX_STP_PORT_STATE    14'h0B04

`define PFLC_RST_FWD_MEMBERSHIP    32'h00000007
`define PFLC_RST_LOOKUP_CTRL       8'h00
`define PFLC_RST_STP_INDEX         8'h00
`define PFLC_RST_STP_STATE         3'h6
`define PFLC_RST_TXQ_BLOCKS        11'h000

// Lookup control fields.
`define PFLC_LK_NULL_VID           7
`define PFLC_LK_INGRESS_FILTER     6
`define PFLC_LK_DROP_NON_PVID      5
`define PFLC_LK_MAC_DOT1X          4
`define PFLC_LK_SELF_FILTER        3
`define PFLC_LK_RW_MASK            8'hFA

// Spanning-tree state fields.
`define PFLC_ST_TX_EN              2
`define PFLC_ST_RX_EN              1
`define PFLC_ST_LEARN_DIS          0

`define PFLC_TXQ_WIDTH             11
`define PFLC_STP_COUNT             8
`define PFLC_VID_ZERO              12'h000
`define PFLC_TXQ_MAX               11'h7FF

`endif

/* design/pflc_port_forward_lookup_ctrl.v */
/*
  Per-port forwarding membership, transmit-queue block count, address
  lookup control and spanning-tree instance state, with an AHB-Lite slave.
  Assumes all packet-side inputs come from logic on the same clock, and
  that the VLAN table membership and switch MAC arrive from other blocks.
*/
// Our own choice: the AHB-Lite interface to the registers.
`include "pflc_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module pflc_port_forward_lookup_ctrl (
  input  wire        clock,
  input  wire        sys_rst,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Forwarding request from this port.
  input  wire [2:0]  fwdDestIn,
  output reg  [2:0]  fwdDestAllowed,
  // Transmit-queue memory block events.
  input  wire        blockAlloc,
  input  wire        blockFree,
  // Received packet presented to the lookup stage.
  input  wire        rxValid,
  input  wire        rxTagged,
  input  wire [11:0] rxVid,
  input  wire [11:0] portDefaultVid,
  input  wire        vlanIngressMember,
  input  wire [47:0] rxSrcMac,
  input  wire [47:0] switchMac,
  input  wire        globalSelfFilterEn,
  input  wire [2:0]  rxStpInstance,
  output reg         lookupValid,
  output reg  [11:0] lookupVid,
  output reg         rxDiscard,
  output reg         learnAllowed,
  output reg         macDot1xEnable,
  // Transmit gating for the instance of the outgoing frame.
  input  wire [2:0]  txStpInstance,
  output reg         txAllowed
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  reg [31:0] fwdMembership;
  reg [7:0]  lookupCtrl;
  reg [7:0]  stpIndex;
  reg [2:0]  stpState [0:`PFLC_STP_COUNT-1];
  reg [`PFLC_TXQ_WIDTH-1:0] txQueueBlocksUsed;

  // The membership word keeps all 32 bits writable and the instance
  // index keeps all eight bits writable, so software reads back exactly
  // what it wrote. Only the low bits of each take part in any decision.
  //
  // The eight instance states live in one small array. A write through
  // the state register lands in the entry that the index held when the
  // data phase completed, not when the address phase was accepted.
  // Software that changes the index must therefore let that write
  // finish before it issues the state access, which the bus ordering
  // already guarantees for a single master.

  reg        wrPend;
  reg        rdPend;
  reg [13:0] wrIndex;
  reg [13:0] rdIndex;

  integer i;

  // Maps a byte address onto a register index; misaligned or out-of-range
  // addresses yield an index that decodes to nothing.
  function [13:0] toIndex;
    input [31:0] addr;
    begin
      if (addr[31:16] != 16'h0000 || addr[1:0] != 2'b00) begin
        toIndex = 14'h3FFF;
      end else begin
        toIndex = addr[15:2];
      end
    end
  endfunction

  // Read multiplexer. Eight-bit registers sit in the low byte of their
  // word and the rest of the word reads as zero. The reserved word at the
  // head of the queue section has no storage and falls into the default
  // branch, so it reads zero and ignores writes.
  function [31:0] readMux;
    input [13:0] idx;
    begin
      case (idx)
        `PFLC_IDX_FWD_MEMBERSHIP: begin
          readMux = fwdMembership;
        end
        `PFLC_IDX_TXQ_MEM_USAGE: begin
          readMux = {21'h000000, txQueueBlocksUsed};
        end
        `PFLC_IDX_LOOKUP_CTRL: begin
          readMux = {24'h000000, lookupCtrl};
        end
        `PFLC_IDX_STP_INDEX: begin
          readMux = {24'h000000, stpIndex};
        end
        `PFLC_IDX_STP_PORT_STATE: begin
          readMux = {29'h00000000, stpState[stpIndex[2:0]]};
        end
        default: begin
          readMux = 32'h00000000;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave. Writes take no wait state. Reads take one wait state so the
  // read data reflect a write whose data phase overlaps the read's address
  // phase, such as a pointer update followed directly by a state read.

  // A transfer is accepted only when the bus is ready, so an address
  // phase that overlaps our own wait state is held by the master and
  // taken again on the following edge.
  // hsize is not decoded: every access is treated as a whole word, and a
  // narrower write replaces the whole register. This is a limitation
  // that a master issuing byte or halfword stores must be aware of.
  // The response is always OKAY, including for unmapped addresses, so a
  // stray access is silently absorbed rather than raising a bus error.

  wire accept = hsel & htrans[1] & hready;

  always @(posedge clock) begin
    if (sys_rst) begin
      wrPend    <= 1'b0;
      rdPend    <= 1'b0;
      wrIndex   <= 14'h0000;
      rdIndex   <= 14'h0000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend <= accept & hwrite;
      rdPend <= accept & ~hwrite;
      if (accept) begin
        wrIndex <= toIndex(haddr);
        rdIndex <= toIndex(haddr);
      end
      hresp <= 1'b0;
      if (accept & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rdPend) begin
        hreadyout <= 1'b1;
        hrdata    <= readMux(rdIndex);
      end else begin
        hreadyout <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers.
  // Writes land at the end of the data phase, when hwdata is valid. The
  // read-only count and the reserved words fall into the default branch
  // and keep their value. Bits 2 and 0 of the lookup control byte are
  // masked so they always read as zero, whatever software writes.

  always @(posedge clock) begin
    if (sys_rst) begin
      fwdMembership <= `PFLC_RST_FWD_MEMBERSHIP;
      lookupCtrl    <= `PFLC_RST_LOOKUP_CTRL;
      stpIndex      <= `PFLC_RST_STP_INDEX;
      for (i = 0; i < `PFLC_STP_COUNT; i = i + 1) begin
        stpState[i] <= `PFLC_RST_STP_STATE;
      end
    end else if (wrPend) begin
      case (wrIndex)
        `PFLC_IDX_FWD_MEMBERSHIP: begin
          fwdMembership <= hwdata;
        end
        `PFLC_IDX_LOOKUP_CTRL: begin
          lookupCtrl <= hwdata[7:0] & `PFLC_LK_RW_MASK;
        end
        `PFLC_IDX_STP_INDEX: begin
          stpIndex <= hwdata[7:0];
        end
        `PFLC_IDX_STP_PORT_STATE: begin
          stpState[stpIndex[2:0]] <= hwdata[2:0];
        end
        default: begin
          fwdMembership <= fwdMembership;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit-queue block count. Saturates at both ends so a stray release
  // or an overrun cannot wrap the reading.
  // An allocation and a release in the same cycle cancel out, so the
  // count holds. The count is not writable; software sees it change in
  // the read that follows the edge after each event.
  // Saturation hides an accounting error in the queue manager instead of
  // flagging it; the trade was a stable reading over a diagnostic.

  always @(posedge clock) begin
    if (sys_rst) begin
      txQueueBlocksUsed <= `PFLC_RST_TXQ_BLOCKS;
    end else if (blockAlloc && !blockFree &&
                 txQueueBlocksUsed != `PFLC_TXQ_MAX) begin
      txQueueBlocksUsed <= txQueueBlocksUsed + 11'h001;
    end else if (blockFree && !blockAlloc &&
                 txQueueBlocksUsed != `PFLC_RST_TXQ_BLOCKS) begin
      txQueueBlocksUsed <= txQueueBlocksUsed - 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet-side decisions, one cycle after the inputs.
  // Every decision is made from the control bits as they stand in the
  // cycle the packet fields are presented, so a control write and a
  // packet in the same cycle see the old setting.
  // The discard causes are independent and are simply ORed: any one of
  // them drops the packet. The VID used for the non-default check is the
  // lookup VID, so a null-VID packet that falls back to the default VID
  // is never dropped by that check.
  // Learning is reported only for a valid packet, and it follows the
  // instance of the received packet, not the instance index register.

  wire [2:0] rxState   = stpState[rxStpInstance];
  wire [2:0] txState   = stpState[txStpInstance];
  wire       nullVid   = rxTagged && rxVid == `PFLC_VID_ZERO;
  wire       selfFilt  = lookupCtrl[`PFLC_LK_SELF_FILTER] & globalSelfFilterEn;

  reg [11:0] next_lookupVid;
  reg        next_rxDiscard;

  always @* begin
    if (nullVid && !lookupCtrl[`PFLC_LK_NULL_VID]) begin
      next_lookupVid = portDefaultVid;
    end else if (!rxTagged) begin
      next_lookupVid = portDefaultVid;
    end else begin
      next_lookupVid = rxVid;
    end
    next_rxDiscard = 1'b0;
    if (lookupCtrl[`PFLC_LK_INGRESS_FILTER] && !vlanIngressMember) begin
      next_rxDiscard = 1'b1;
    end
    if (lookupCtrl[`PFLC_LK_DROP_NON_PVID] &&
        next_lookupVid != portDefaultVid) begin
      next_rxDiscard = 1'b1;
    end
    if (selfFilt && rxSrcMac == switchMac) begin
      next_rxDiscard = 1'b1;
    end
    if (!rxState[`PFLC_ST_RX_EN]) begin
      next_rxDiscard = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered packet-side outputs.
  // All outputs come straight from flip-flops and stand for one cycle.
  // Forwarding and transmit gating are not qualified by a packet valid, so
  // downstream logic must qualify them with its own strobe.

  always @(posedge clock) begin
    if (sys_rst) begin
      fwdDestAllowed <= 3'h0;
      lookupValid    <= 1'b0;
      lookupVid      <= 12'h000;
      rxDiscard      <= 1'b0;
      learnAllowed   <= 1'b0;
      macDot1xEnable <= 1'b0;
      txAllowed      <= 1'b0;
    end else begin
      fwdDestAllowed <= fwdDestIn & fwdMembership[2:0];
      lookupValid    <= rxValid;
      lookupVid      <= next_lookupVid;
      rxDiscard      <= rxValid & next_rxDiscard;
      learnAllowed   <= rxValid & ~rxState[`PFLC_ST_LEARN_DIS];
      macDot1xEnable <= lookupCtrl[`PFLC_LK_MAC_DOT1X];
      txAllowed      <= txState[`PFLC_ST_TX_EN];
    end
  end

endmodule // pflc_port_forward_lookup_ctrl

`default_nettype wire

/* dv/pflc_checker_props.sv */
/* Port checker for the forwarding and lookup control bank.
   Assumes hready is tied to hreadyout by the bus fabric. */
`timescale 1ns/100ps
`default_nettype none
module pflc_checker (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  fwdDestIn,
  input wire logic [2:0]  fwdDestAllowed,
  input wire logic        rxValid,
  input wire logic        rxTagged,
  input wire logic [11:0] rxVid,
  input wire logic [11:0] portDefaultVid,
  input wire logic        lookupValid,
  input wire logic [11:0] lookupVid,
  input wire logic        rxDiscard,
  input wire logic        learnAllowed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic take = hsel & htrans[1] & hready;
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_ready_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  fwd_gate_a: assert property ((fwdDestAllowed & ~$past(fwdDestIn)) == 3'h0)
    else $error("forward to unrequested port");
  lookup_pipe_a: assert property (!$past(sys_rst) |-> lookupValid == $past(rxValid))
    else $error("lookup valid lag wrong");
  vid_untag_a: assert property (rxValid && !rxTagged |=> lookupVid == $past(portDefaultVid))
    else $error("untagged vid wrong");
  vid_tagged_a: assert property (rxValid && rxTagged && rxVid != 12'h000
    |=> lookupVid == $past(rxVid))
    else $error("tagged vid wrong");
  discard_qual_a: assert property (rxDiscard |-> $past(rxValid))
    else $error("discard without packet");
  learn_qual_a: assert property (learnAllowed |-> $past(rxValid))
    else $error("learn without packet");
endmodule // pflc_checker
bind pflc_port_forward_lookup_ctrl pflc_checker chk_u (.clock, .sys_rst, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .fwdDestIn, .fwdDestAllowed,
  .rxValid, .rxTagged, .rxVid, .portDefaultVid, .lookupValid, .lookupVid,
  .rxDiscard, .learnAllowed);
`default_nettype wire

/* dv/port_forward_lookup_ctrl_tb_top.sv */
/* Bench for the forwarding and lookup control bank.
   Assumes the one-wait-state read and registered packet outputs. */
`timescale 1ns/100ps
`default_nettype none
module port_forward_lookup_ctrl_tb_top;
  logic clock = 0, sys_rst = 1, hsel = 0, hwrite = 0, rxValid = 0;
  logic rxTagged = 0, blockAlloc = 0, blockFree = 0, vlanIngressMember = 0;
  logic globalSelfFilterEn = 0, hreadyout, hresp, lookupValid, rxDiscard;
  logic learnAllowed, macDot1xEnable, txAllowed, t, mb, m, g, d;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, fwdDestIn = 0, rxStpInstance = 0;
  logic [2:0] txStpInstance = 0, fwdDestAllowed;
  logic [7:0] c;
  logic [11:0] rxVid = 0, portDefaultVid = 12'h064, lookupVid, v, ev;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [47:0] rxSrcMac = 0, switchMac = 48'h0A1B2C3D4E5F;
  logic [31:0] ra [6] = '{32'h2800, 32'h2810, 32'h2840, 32'h2C00, 32'h2C04, 32'h2C10};
  logic [31:0] rv [6] = '{32'h0, 32'h7, 32'h0, 32'h0, 32'h0, 32'h6};
  logic [1:0] bp [6] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h1, 2'h3};
  logic [24:0] lc [9] = '{{8'h00, 13'h1000, 4'h8}, {8'h80, 13'h1000, 4'h8},
    {8'h40, 13'h1064, 4'h1}, {8'h40, 13'h1064, 4'h8}, {8'h20, 13'h1005, 4'h9},
    {8'h20, 13'h0005, 4'h8}, {8'h08, 13'h1064, 4'hF}, {8'h08, 13'h1064, 4'hC},
    {8'h10, 13'h1005, 4'h6}};
  int err_count = 0, comparisons = 0;
  pflc_port_forward_lookup_ctrl dut_u (.clock, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .fwdDestIn, .fwdDestAllowed, .blockAlloc, .blockFree, .rxValid, .rxTagged,
    .rxVid, .portDefaultVid, .vlanIngressMember, .rxSrcMac, .switchMac,
    .globalSelfFilterEn, .rxStpInstance, .lookupValid, .lookupVid, .rxDiscard,
    .learnAllowed, .macDot1xEnable, .txStpInstance, .txAllowed);
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask
  // The value seen at a falling edge is what the next rising edge samples.
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, dt);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dt;
    rdy();
    q = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, q);
  endtask
  task automatic step;
    @(posedge clock);
    @(negedge clock);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    bus(1'b1, 32'h2810, 32'h5);
    rd(32'h2810, 32'h5);
    @(posedge clock);
    fwdDestIn <= 3'h7;
    rxTagged <= 1'b1;
    step();
    chk("fwdDestAllowed", 32'h5, 32'(fwdDestAllowed));
    chk("hresp", 32'h0, 32'(hresp));
    foreach (bp[i]) begin
      @(posedge clock);
      {blockAlloc, blockFree} <= bp[i];
    end
    @(posedge clock);
    {blockAlloc, blockFree} <= 2'h0;
    rd(32'h2840, 32'h2);
    bus(1'b1, 32'h2840, 32'h7FF);
    rd(32'h2840, 32'h2);
    bus(1'b1, 32'h2C04, 32'h5);
    bus(1'b1, 32'h2C10, 32'h1);
    rd(32'h2C10, 32'h1);
    bus(1'b1, 32'h2C04, 32'h0);
    rd(32'h2C10, 32'h6);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      rxValid <= 1'b1;
      rxStpInstance <= k ? 3'h0 : 3'h5;
      txStpInstance <= k ? 3'h0 : 3'h5;
      step();
      chk("txAllowed", 32'(k), 32'(txAllowed));
      chk("rxDiscard", 32'(!k), 32'(rxDiscard));
      chk("learnAllowed", 32'(k), 32'(learnAllowed));
    end
    bus(1'b1, 32'h2C00, 32'hFF);
    rd(32'h2C00, 32'hFA);
    foreach (lc[i]) begin
      {c, t, v, mb, m, g, d} = lc[i];
      bus(1'b1, 32'h2C00, {24'h0, c});
      @(posedge clock);
      rxTagged <= t;
      rxVid <= v;
      vlanIngressMember <= mb;
      globalSelfFilterEn <= g;
      rxSrcMac <= m ? switchMac : ~switchMac;
      step();
      ev = (!t || (v == 12'h000 && !c[7])) ? portDefaultVid : v;
      chk("lookupValid", 32'h1, 32'(lookupValid));
      chk("lookupVid", 32'(ev), 32'(lookupVid));
      chk("rxDiscard", 32'(d), 32'(rxDiscard));
      chk("macDot1xEnable", 32'(c[4]), 32'(macDot1xEnable));
    end
    end_of_test();
  end
endmodule // port_forward_lookup_ctrl_tb_top
`default_nettype wire
